// *** src/atf_pkg.sv ***
/*
  atf_pkg: task-file addresses, register reset values, bit positions and
  timing constants shared by the task-file register block.
  Assumes a 40 MHz device clock and a 3-bit task-file address plus a
  separate control-block select from the host port decoder.
*/
package atf_pkg;
  // ----------------------------------------------------------------------
  // task-file addresses (command block, cs0 side)
  // ----------------------------------------------------------------------
  localparam logic [2:0] TF_DATA = 3'h0;
  localparam logic [2:0] TF_FEAT_ERR = 3'h1;
  localparam logic [2:0] TF_SECCNT = 3'h2;
  localparam logic [2:0] TF_SECNUM = 3'h3;
  localparam logic [2:0] TF_CYLLO = 3'h4;
  localparam logic [2:0] TF_CYLHI = 3'h5;
  localparam logic [2:0] TF_DRVHEAD = 3'h6;
  localparam logic [2:0] TF_STAT_CMD = 3'h7;
  // control block: device control at address 6 (alt status on read)
  localparam logic [2:0] TF_DEVCTL = 3'h6;
  localparam int SOFT_RESET_BIT = 2;

  // ----------------------------------------------------------------------
  // reset values and command-reject values
  // ----------------------------------------------------------------------
  localparam logic [7:0] STAT_RST = 8'h00;
  localparam logic [7:0] STAT_PKT_RST = 8'h10;
  localparam logic [7:0] STAT_REJECT = 8'h41;
  localparam logic [7:0] ERR_RST = 8'h01;
  localparam logic [7:0] ERR_REJECT = 8'h04;
  localparam logic [7:0] SECCNT_RST = 8'h01;
  localparam logic [7:0] SECNUM_RST = 8'h01;
  localparam logic [7:0] CYLLO_RST = 8'h14;
  localparam logic [7:0] CYLHI_RST = 8'heb;
  localparam logic [7:0] DRVHEAD_RST = 8'h00;
  localparam logic [7:0] FEAT_RST = 8'h00;

  // ----------------------------------------------------------------------
  // status, error and feature bit positions
  // ----------------------------------------------------------------------
  localparam int ST_LOCKED = 7;
  localparam int ST_READY = 6;
  localparam int ST_SEEK = 4;
  localparam int ST_XFER = 3;
  localparam int ST_CHECK = 0;
  localparam int ER_KEY_HI = 7;
  localparam int ER_KEY_LO = 4;
  localparam int ER_REJECT = 2;
  localparam int ER_PEND = 1;
  localparam int ER_BADLEN = 0;
  localparam int FT_DMA = 0;

  // ----------------------------------------------------------------------
  // power-up handshake timing
  // ----------------------------------------------------------------------
  localparam int CLK_HZ = 40_000_000;
  localparam int HANDSHAKE_MS = 31;
  localparam int HANDSHAKE_CYC = CLK_HZ / 1000 * HANDSHAKE_MS;
endpackage

// *** src/atf_sync2.sv ***
/*
  atf_sync2: two-flop level synchroniser for host pins.
  Assumes inputs are asynchronous levels; first flop feeds only the second.
*/
`timescale 1ns/100ps
`default_nettype none
module atf_sync2 #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // level in and out
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] nxt_meta;
  logic [W-1:0] nxt_sync;

  // -----------------------------------------------------------------------
  // two stages
  // -----------------------------------------------------------------------
  always_comb begin
    nxt_meta = async_i;
    nxt_sync = meta_ff;
  end

  always_ff @(posedge sys_clk_i) begin
    // idle level of the active-low pins, so no false pulse follows reset
    if (!rst_b_i) begin
      meta_ff <= '1;
      sync_o <= '1;
    end else begin
      meta_ff <= nxt_meta;
      sync_o <= nxt_sync;
    end
  end
endmodule // atf_sync2
`default_nettype wire

// *** src/atf_regs.sv ***
/*
  atf_regs: device-side task-file registers of a packet-interface unit.
  Assumes the host strobes are decoded to single-cycle pulses in the
  device clock domain, and that the firmware side reports command events
  as one-cycle pulses. Active-low pins arrive raw and are synchronised.
*/
// Behaviour
// (R1) resets load status 00, error 01, count/number 01, 14/eb; packet reset 10
// (R2) soft-bit reset or abort hides seek-complete and clears ready
// (R3) packet command acceptance restores ready and seek-complete visibility
// (R4) locked-out bit set while only the device owns the task file
// (R5) ready only while seek-complete holds a valid value
// (R6) seek-complete set when the device can accept a command
// (R7) transfer-request set while data is ready to move
// (R8) check bit set when the current command has an error
// (R9) status bits 5, 2, 1 always read zero
// (R10) error bits 7-4 carry the sense key
// (R11) error bit 3 always reads zero
// (R12) error bit 2 set when a command is aborted
// (R13) error bit 1 set at end of partition
// (R14) error bit 0 set when an illegal-length block is read
// (R15) feature bit 0 selects dma (1) or pio (0); packets always pio
// (R16) host writes the method bit before each data-moving packet command
// (R17) command completion overwrites the feature/error location with error
// (R18) wrong method bit may leave busy stuck; host recovers by reset
// (R19) active and diag signals exchanged at power-up for master/slave
// (R20) after power-up the active signal is not driven for activity
// (R21) transfer mode selects rate only; feature bit 0 picks dma or pio
// (R22) error register is read at the feature write address
`timescale 1ns/100ps
`default_nettype none
module atf_regs #(
  parameter int HANDSHAKE_CYC = atf_pkg::HANDSHAKE_CYC
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // host register port (same clock domain)
  input wire logic [2:0] tf_addr_i,
  input wire logic tf_ctl_sel_i,
  input wire logic tf_wr_i,
  input wire logic tf_rd_i,
  input wire logic [7:0] tf_wdata_i,
  output logic [7:0] tf_rdata_o,
  // host pins
  input wire logic hard_reset_n_i,
  input wire logic unit_active_n_i,
  input wire logic diag_passed_n_i,
  output logic unit_active_n_o,
  output logic unit_active_n_oe_o,
  output logic diag_passed_n_o,
  output logic diag_passed_n_oe_o,
  // firmware events and levels
  input wire logic is_slave_i,
  input wire logic diag_ok_i,
  input wire logic pkt_soft_reset_i,
  input wire logic pkt_accept_i,
  input wire logic cmd_reject_i,
  input wire logic cmd_abort_i,
  input wire logic cmd_done_i,
  input wire logic cmd_error_i,
  input wire logic [3:0] sense_key_i,
  input wire logic partition_end_i,
  input wire logic bad_length_i,
  input wire logic dev_owns_tf_i,
  input wire logic seek_ready_i,
  input wire logic data_ready_i,
  // status to firmware
  output logic dma_sel_o,
  output logic soft_reset_o,
  output logic cmd_strobe_o,
  output logic [7:0] cmd_code_o
);
  // -----------------------------------------------------------------------
  // pin synchronisers
  // -----------------------------------------------------------------------
  logic [2:0] pins_s;
  atf_sync2 #(.W(3)) u_sync (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .async_i({hard_reset_n_i, unit_active_n_i, diag_passed_n_i}),
    .sync_o(pins_s)
  );
  wire hard_rst = !pins_s[2];
  wire slave_active = !pins_s[1];

  // -----------------------------------------------------------------------
  // register state
  // -----------------------------------------------------------------------
  logic [7:0] err_ff, nxt_err;
  logic [7:0] feat_ff, nxt_feat;
  logic [7:0] seccnt_ff, nxt_seccnt;
  logic [7:0] secnum_ff, nxt_secnum;
  logic [7:0] cyllo_ff, nxt_cyllo;
  logic [7:0] cylhi_ff, nxt_cylhi;
  logic [7:0] drvhead_ff, nxt_drvhead;
  logic ready_ff, nxt_ready;
  logic seek_vis_ff, nxt_seek_vis;
  logic check_ff, nxt_check;
  logic pkt_stat_ff, nxt_pkt_stat;
  logic soft_reset_bit_ff, nxt_soft_reset_bit;
  logic [7:0] rdata_ff, nxt_rdata;
  logic cmd_stb_ff, nxt_cmd_stb;
  logic [7:0] cmd_ff, nxt_cmd;

  wire wr_cmd = tf_wr_i && !tf_ctl_sel_i;
  wire soft_reset_bit_wr = tf_wr_i && tf_ctl_sel_i && (tf_addr_i == atf_pkg::TF_DEVCTL);
  wire soft_reset_bit_rise = soft_reset_bit_wr && tf_wdata_i[atf_pkg::SOFT_RESET_BIT] && !soft_reset_bit_ff;
  wire full_rst = hard_rst || soft_reset_bit_rise;

  // status byte assembled live; unused bits tied low
  logic [7:0] status;
  always_comb begin
    status = 8'h00; // R9
    status[atf_pkg::ST_LOCKED] = dev_owns_tf_i; // R4
    status[atf_pkg::ST_READY] = ready_ff && seek_vis_ff; // R5
    status[atf_pkg::ST_SEEK] = seek_vis_ff && (seek_ready_i || pkt_stat_ff); // R6
    status[atf_pkg::ST_XFER] = data_ready_i && !dev_owns_tf_i; // R7
    status[atf_pkg::ST_CHECK] = check_ff; // R8
  end

  // -----------------------------------------------------------------------
  // next-state for task file and status flags
  // -----------------------------------------------------------------------
  always_comb begin
    nxt_err = err_ff;
    nxt_feat = feat_ff;
    nxt_seccnt = seccnt_ff;
    nxt_secnum = secnum_ff;
    nxt_cyllo = cyllo_ff;
    nxt_cylhi = cylhi_ff;
    nxt_drvhead = drvhead_ff;
    nxt_ready = ready_ff;
    nxt_seek_vis = seek_vis_ff;
    nxt_check = check_ff;
    nxt_pkt_stat = pkt_stat_ff;
    nxt_soft_reset_bit = soft_reset_bit_ff;
    nxt_cmd_stb = 1'b0;
    nxt_cmd = cmd_ff;
    if (soft_reset_bit_wr) begin
      nxt_soft_reset_bit = tf_wdata_i[atf_pkg::SOFT_RESET_BIT];
    end
    // host writes
    if (wr_cmd) begin
      unique case (tf_addr_i)
        atf_pkg::TF_FEAT_ERR: nxt_feat = tf_wdata_i; // R15 R16
        atf_pkg::TF_SECCNT: nxt_seccnt = tf_wdata_i;
        atf_pkg::TF_SECNUM: nxt_secnum = tf_wdata_i;
        atf_pkg::TF_CYLLO: nxt_cyllo = tf_wdata_i;
        atf_pkg::TF_CYLHI: nxt_cylhi = tf_wdata_i;
        atf_pkg::TF_DRVHEAD: nxt_drvhead = tf_wdata_i;
        atf_pkg::TF_STAT_CMD: begin
          nxt_cmd = tf_wdata_i;
          nxt_cmd_stb = 1'b1;
        end
        default: ;
      endcase
    end
    // completion writes error info into the shared location
    if (cmd_done_i) begin
      nxt_err = {sense_key_i, 1'b0, 1'b0, partition_end_i, bad_length_i}; // R10 R11 R13 R14 R17
      nxt_check = cmd_error_i; // R8
    end
    if (cmd_abort_i) begin
      nxt_err[atf_pkg::ER_REJECT] = 1'b1; // R12
      nxt_check = 1'b1;
      nxt_ready = 1'b0; // R2
      nxt_seek_vis = 1'b0; // R2
    end
    if (pkt_accept_i) begin
      nxt_ready = 1'b1; // R3
      nxt_seek_vis = 1'b1; // R3
    end
    if (cmd_reject_i) begin
      nxt_err = atf_pkg::ERR_REJECT; // R1 R12
      nxt_ready = 1'b1;
      nxt_seek_vis = 1'b1;
      nxt_check = 1'b1;
      nxt_pkt_stat = 1'b0;
    end
    if (pkt_soft_reset_i) begin
      nxt_err = atf_pkg::ERR_RST; // R1
      nxt_seccnt = atf_pkg::SECCNT_RST;
      nxt_secnum = atf_pkg::SECNUM_RST;
      nxt_cyllo = atf_pkg::CYLLO_RST;
      nxt_cylhi = atf_pkg::CYLHI_RST;
      nxt_check = 1'b0;
      nxt_ready = 1'b0;
      nxt_seek_vis = 1'b1; // status reads 10h
      nxt_pkt_stat = 1'b1;
    end
    if (full_rst) begin
      nxt_err = atf_pkg::ERR_RST; // R1
      nxt_seccnt = atf_pkg::SECCNT_RST;
      nxt_secnum = atf_pkg::SECNUM_RST;
      nxt_cyllo = atf_pkg::CYLLO_RST;
      nxt_cylhi = atf_pkg::CYLHI_RST;
      nxt_drvhead = atf_pkg::DRVHEAD_RST;
      nxt_feat = atf_pkg::FEAT_RST; // R18
      nxt_check = 1'b0;
      nxt_ready = 1'b0; // R2
      nxt_seek_vis = 1'b0; // R2
      nxt_pkt_stat = 1'b0;
    end
    if (pkt_accept_i || cmd_reject_i) begin
      nxt_pkt_stat = 1'b0;
    end
  end

  // -----------------------------------------------------------------------
  // host read path, registered
  // -----------------------------------------------------------------------
  always_comb begin
    nxt_rdata = rdata_ff;
    if (tf_rd_i) begin
      if (tf_ctl_sel_i) begin
        nxt_rdata = (tf_addr_i == atf_pkg::TF_DEVCTL) ? status : 8'h00;
      end else begin
        unique case (tf_addr_i)
          atf_pkg::TF_FEAT_ERR: nxt_rdata = err_ff; // R22
          atf_pkg::TF_SECCNT: nxt_rdata = seccnt_ff;
          atf_pkg::TF_SECNUM: nxt_rdata = secnum_ff;
          atf_pkg::TF_CYLLO: nxt_rdata = cyllo_ff;
          atf_pkg::TF_CYLHI: nxt_rdata = cylhi_ff;
          atf_pkg::TF_DRVHEAD: nxt_rdata = drvhead_ff;
          atf_pkg::TF_STAT_CMD: nxt_rdata = status;
          default: nxt_rdata = 8'h00; // data port lives elsewhere
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      err_ff <= atf_pkg::ERR_RST;
      feat_ff <= atf_pkg::FEAT_RST;
      seccnt_ff <= atf_pkg::SECCNT_RST;
      secnum_ff <= atf_pkg::SECNUM_RST;
      cyllo_ff <= atf_pkg::CYLLO_RST;
      cylhi_ff <= atf_pkg::CYLHI_RST;
      drvhead_ff <= atf_pkg::DRVHEAD_RST;
      ready_ff <= 1'b0;
      seek_vis_ff <= 1'b0;
      check_ff <= 1'b0;
      pkt_stat_ff <= 1'b0;
      soft_reset_bit_ff <= 1'b0;
      rdata_ff <= atf_pkg::STAT_RST;
      cmd_stb_ff <= 1'b0;
      cmd_ff <= 8'h00;
    end else begin
      err_ff <= nxt_err;
      feat_ff <= nxt_feat;
      seccnt_ff <= nxt_seccnt;
      secnum_ff <= nxt_secnum;
      cyllo_ff <= nxt_cyllo;
      cylhi_ff <= nxt_cylhi;
      drvhead_ff <= nxt_drvhead;
      ready_ff <= nxt_ready;
      seek_vis_ff <= nxt_seek_vis;
      check_ff <= nxt_check;
      pkt_stat_ff <= nxt_pkt_stat;
      soft_reset_bit_ff <= nxt_soft_reset_bit;
      rdata_ff <= nxt_rdata;
      cmd_stb_ff <= nxt_cmd_stb;
      cmd_ff <= nxt_cmd;
    end
  end

  // -----------------------------------------------------------------------
  // power-up master/slave handshake
  // -----------------------------------------------------------------------
  typedef enum logic [2:0] {
    ATF_HS_IDLE = 3'b001,
    ATF_HS_RUN = 3'b010,
    ATF_HS_DONE = 3'b100
  } atf_hs_t;
  atf_hs_t hs_ff, nxt_hs;
  logic [31:0] hs_cnt_ff, nxt_hs_cnt;
  logic act_oe_ff, nxt_act_oe;
  logic diag_oe_ff, nxt_diag_oe;

  // slave asserts active then asserts diag-passed once diag_ok_i; master
  // listens only. activity is never shown here, a front LED does that.
  always_comb begin
    nxt_hs = hs_ff;
    nxt_hs_cnt = hs_cnt_ff;
    nxt_act_oe = act_oe_ff;
    nxt_diag_oe = diag_oe_ff;
    unique case (hs_ff)
      ATF_HS_IDLE: begin
        nxt_hs = ATF_HS_RUN;
        nxt_hs_cnt = 32'h0;
        nxt_act_oe = is_slave_i; // R19
        nxt_diag_oe = 1'b0;
      end
      ATF_HS_RUN: begin
        nxt_hs_cnt = hs_cnt_ff + 32'h1;
        if (is_slave_i && diag_ok_i) begin
          nxt_diag_oe = 1'b1; // R19
        end
        if (hs_cnt_ff >= 32'(HANDSHAKE_CYC - 1) || (!is_slave_i && !slave_active && diag_ok_i)) begin
          nxt_hs = ATF_HS_DONE;
          nxt_act_oe = 1'b0; // R20
          nxt_diag_oe = 1'b0;
        end
      end
      ATF_HS_DONE: begin
        nxt_act_oe = 1'b0; // R20
        nxt_diag_oe = 1'b0;
      end
      default: nxt_hs = ATF_HS_IDLE;
    endcase
    if (hard_rst || soft_reset_bit_rise) begin
      nxt_hs = ATF_HS_IDLE;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      hs_ff <= ATF_HS_IDLE;
      hs_cnt_ff <= 32'h0;
      act_oe_ff <= 1'b0;
      diag_oe_ff <= 1'b0;
    end else begin
      hs_ff <= nxt_hs;
      hs_cnt_ff <= nxt_hs_cnt;
      act_oe_ff <= nxt_act_oe;
      diag_oe_ff <= nxt_diag_oe;
    end
  end

  // -----------------------------------------------------------------------
  // outputs, all flops or constant pin levels
  // -----------------------------------------------------------------------
  always_comb begin
    tf_rdata_o = rdata_ff;
    unit_active_n_o = 1'b0; // drives low only, open-drain style
    unit_active_n_oe_o = act_oe_ff;
    diag_passed_n_o = 1'b0;
    diag_passed_n_oe_o = diag_oe_ff;
    dma_sel_o = feat_ff[atf_pkg::FT_DMA]; // R15 R21
    soft_reset_o = soft_reset_bit_ff;
    cmd_strobe_o = cmd_stb_ff;
    cmd_code_o = cmd_ff;
  end

  // -----------------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------------
  a_zero_status_bits: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // R9
    (tf_rd_i && !tf_ctl_sel_i && tf_addr_i == atf_pkg::TF_STAT_CMD)
    |=> ((tf_rdata_o[5] == 1'b0) && (tf_rdata_o[2] == 1'b0) && (tf_rdata_o[1] == 1'b0)))
    else $error("unused status bits not zero");
  a_err_bit3_zero: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    err_ff[3] == 1'b0) else $error("error bit 3 set"); // R11
  a_ready_needs_seek: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    ready_ff |-> seek_vis_ff) else $error("ready without seek valid"); // R5
  a_reset_loads: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    soft_reset_bit_rise |=> (err_ff == atf_pkg::ERR_RST && cyllo_ff == atf_pkg::CYLLO_RST
    && cylhi_ff == atf_pkg::CYLHI_RST && !ready_ff)) else $error("soft reset values wrong"); // R1
  a_abort_clears: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (cmd_abort_i && !pkt_accept_i && !cmd_reject_i && !full_rst && !pkt_soft_reset_i)
    |=> (!ready_ff && !seek_vis_ff && err_ff[atf_pkg::ER_REJECT])) else $error("abort not seen"); // R2
  a_accept_ready: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (pkt_accept_i && !full_rst) |=> (ready_ff && seek_vis_ff)) else $error("accept not ready"); // R3
  a_busy_tracks: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (tf_rd_i && !tf_ctl_sel_i && tf_addr_i == atf_pkg::TF_STAT_CMD)
    |=> (tf_rdata_o[atf_pkg::ST_LOCKED] == $past(dev_owns_tf_i))) else $error("busy wrong"); // R4
  a_done_errinfo: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (cmd_done_i && !cmd_abort_i && !cmd_reject_i && !full_rst && !pkt_soft_reset_i)
    |=> (err_ff[7:4] == $past(sense_key_i) && check_ff == $past(cmd_error_i)))
    else $error("completion error info wrong"); // R17
  a_no_drive_after: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (hs_ff == ATF_HS_DONE) |-> !unit_active_n_oe_o) else $error("active driven after power-up"); // R20
endmodule // atf_regs
`default_nettype wire

// *** dv/atf_host_model.sv ***
/*
  atf_host_model: host side of the task-file port, owning the hard reset
  pin and the pulled-up active and diag lines shared with a peer unit.
  Assumes the bench drives its requests just after a rising clock edge.
*/
`timescale 1ns/100ps
`default_nettype none
module atf_host_model (
  // clock
  input wire logic sys_clk_i,
  // bench requests
  input wire logic hard_rst_req_i,
  input wire logic peer_active_i,
  input wire logic peer_diag_i,
  // device pin enables
  input wire logic dev_active_oe_i,
  input wire logic dev_diag_oe_i,
  // resolved pins
  output logic hard_reset_n_o,
  output logic active_line_o,
  output logic diag_line_o
);
  // ----------------------------------------------------------------------
  // pins
  // ----------------------------------------------------------------------
  // host recovers a stuck unit by pulsing the reset pin
  always_ff @(posedge sys_clk_i) begin
    hard_reset_n_o <= !hard_rst_req_i;
  end

  // open-drain lines: pull-up unless anyone pulls low, so no stale level
  assign active_line_o = !(dev_active_oe_i || peer_active_i);
  assign diag_line_o = !(dev_diag_oe_i || peer_diag_i);
endmodule // atf_host_model
`default_nettype wire

// *** dv/atf_regs_tb.sv ***
/*
  atf_regs_tb: self-checking bench for the task-file register block.
  Assumes single-cycle read/write pulses and one-cycle firmware events.
*/
`timescale 1ns/100ps
`default_nettype none
module atf_regs_tb;
  localparam int HS = 50;
  logic sys_clk, rst_b, tf_ctl_sel, tf_wr, tf_rd, hard_req;
  logic [2:0] tf_addr;
  logic [7:0] tf_wdata, tf_rdata;
  logic [4:0] ev;
  logic cmd_error, pend, badlen, dev_owns, seek_rdy, data_rdy, is_slave, diag_ok;
  logic [3:0] sense;
  logic hard_n, act_line, diag_line, act_oe, diag_oe, dma_sel, soft_rst, cmd_strobe;
  logic [7:0] cmd_code;
  int error_cnt;
  int checks_done;

  // ----------------------------------------------------------------------
  // clock, design and host
  // ----------------------------------------------------------------------
  always #12.5 sys_clk = !sys_clk;

  atf_regs #(.HANDSHAKE_CYC(HS)) atf_regs_i (
    .sys_clk_i(sys_clk), .rst_b_i(rst_b), .tf_addr_i(tf_addr), .tf_ctl_sel_i(tf_ctl_sel),
    .tf_wr_i(tf_wr), .tf_rd_i(tf_rd), .tf_wdata_i(tf_wdata), .tf_rdata_o(tf_rdata),
    .hard_reset_n_i(hard_n), .unit_active_n_i(act_line), .diag_passed_n_i(diag_line),
    .unit_active_n_o(), .unit_active_n_oe_o(act_oe), .diag_passed_n_o(),
    .diag_passed_n_oe_o(diag_oe), .is_slave_i(is_slave), .diag_ok_i(diag_ok),
    .pkt_soft_reset_i(ev[4]), .pkt_accept_i(ev[2]), .cmd_reject_i(ev[3]),
    .cmd_abort_i(ev[1]), .cmd_done_i(ev[0]), .cmd_error_i(cmd_error),
    .sense_key_i(sense), .partition_end_i(pend), .bad_length_i(badlen),
    .dev_owns_tf_i(dev_owns), .seek_ready_i(seek_rdy), .data_ready_i(data_rdy),
    .dma_sel_o(dma_sel), .soft_reset_o(soft_rst), .cmd_strobe_o(cmd_strobe), .cmd_code_o(cmd_code)
  );

  atf_host_model atf_host_model_i (
    .sys_clk_i(sys_clk), .hard_rst_req_i(hard_req), .peer_active_i(1'b0),
    .peer_diag_i(1'b0), .dev_active_oe_i(act_oe), .dev_diag_oe_i(diag_oe),
    .hard_reset_n_o(hard_n), .active_line_o(act_line), .diag_line_o(diag_line)
  );

  // ----------------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------------
  // compare and count; four-state so an unknown never matches
  task chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one write pulse, launched after an edge and taken at the next
  task wr(input logic ctl, input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    tf_wr <= 1'b1;
    tf_ctl_sel <= ctl;
    tf_addr <= a;
    tf_wdata <= d;
    @(posedge sys_clk);
    tf_wr <= 1'b0;
    #1;
  endtask

  // read pulse; data is registered at the taking edge, so look just after
  task rd(input logic ctl, input logic [2:0] a, input logic [7:0] m, input logic [7:0] exp);
    @(posedge sys_clk);
    tf_rd <= 1'b1;
    tf_ctl_sel <= ctl;
    tf_addr <= a;
    @(posedge sys_clk);
    tf_rd <= 1'b0;
    #1;
    chk(tf_rdata & m, exp);
  endtask

  // one-cycle firmware event on bit b of ev
  task pulse(input int b);
    @(posedge sys_clk);
    ev <= 5'h01 << b;
    @(posedge sys_clk);
    ev <= 5'h00;
  endtask

  // values loaded by every full reset
  task chk_regs;
    rd(1'b0, atf_pkg::TF_FEAT_ERR, 8'hff, atf_pkg::ERR_RST);
    rd(1'b0, atf_pkg::TF_SECCNT, 8'hff, atf_pkg::SECCNT_RST);
    rd(1'b0, atf_pkg::TF_SECNUM, 8'hff, atf_pkg::SECNUM_RST);
    rd(1'b0, atf_pkg::TF_CYLLO, 8'hff, atf_pkg::CYLLO_RST);
    rd(1'b0, atf_pkg::TF_CYLHI, 8'hff, atf_pkg::CYLHI_RST);
    rd(1'b0, atf_pkg::TF_DRVHEAD, 8'hff, atf_pkg::DRVHEAD_RST);
    rd(1'b0, atf_pkg::TF_STAT_CMD, 8'hff, atf_pkg::STAT_RST);
  endtask

  task conclude;
    $display("errors=%0d checks=%0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // watchdog: the sequence needs well under a thousand cycles
  // ----------------------------------------------------------------------
  initial begin
    repeat (5000) @(posedge sys_clk);
    error_cnt++;
    conclude;
  end

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    sys_clk = 1'b0; rst_b = 1'b0; tf_ctl_sel = 1'b0; tf_wr = 1'b0; tf_rd = 1'b0;
    tf_addr = 3'h0; tf_wdata = 8'h00; ev = 5'h00; hard_req = 1'b0;
    cmd_error = 1'b0; pend = 1'b0; badlen = 1'b0; sense = 4'h0; dev_owns = 1'b0;
    seek_rdy = 1'b0; data_rdy = 1'b0; is_slave = 1'b1; diag_ok = 1'b1;
    error_cnt = 0; checks_done = 0;
    repeat (8) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge sys_clk);
    // slave announces itself on the active line during power-up
    chk({7'h00, act_line}, 8'h00);
    chk({7'h00, diag_line}, 8'h00);
    chk_regs;
    // method bit lands in dma select; same address reads back the error
    wr(1'b0, atf_pkg::TF_FEAT_ERR, 8'hfe);
    chk({7'h00, dma_sel}, 8'h00);
    wr(1'b0, atf_pkg::TF_FEAT_ERR, 8'h01);
    chk({7'h00, dma_sel}, 8'h01);
    rd(1'b0, atf_pkg::TF_FEAT_ERR, 8'hff, atf_pkg::ERR_RST);
    // command write hands the code to firmware with a one-cycle strobe
    wr(1'b0, atf_pkg::TF_STAT_CMD, 8'ha1);
    chk(cmd_code, 8'ha1);
    chk({7'h00, cmd_strobe}, 8'h01);
    @(posedge sys_clk);
    #1;
    chk({7'h00, cmd_strobe}, 8'h00);
    // accepted packet command brings ready and seek-complete
    seek_rdy <= 1'b1;
    pulse(2);
    rd(1'b0, atf_pkg::TF_STAT_CMD, 8'hff, 8'h50);
    rd(1'b1, atf_pkg::TF_DEVCTL, 8'hff, 8'h50);
    // busy tracks ownership, data request hidden while busy
    dev_owns <= 1'b1;
    data_rdy <= 1'b1;
    rd(1'b0, atf_pkg::TF_STAT_CMD, 8'hff, 8'hd0);
    dev_owns <= 1'b0;
    rd(1'b0, atf_pkg::TF_STAT_CMD, 8'hff, 8'h58);
    data_rdy <= 1'b0;
    // completion with error: sense key, partition end, bad length
    cmd_error <= 1'b1; sense <= 4'ha; pend <= 1'b1; badlen <= 1'b1;
    pulse(0);
    rd(1'b0, atf_pkg::TF_FEAT_ERR, 8'hff, 8'ha3);
    rd(1'b0, atf_pkg::TF_STAT_CMD, 8'hff, 8'h51);
    cmd_error <= 1'b0; sense <= 4'h5; pend <= 1'b0;
    pulse(0);
    rd(1'b0, atf_pkg::TF_FEAT_ERR, 8'hff, 8'h51);
    rd(1'b0, atf_pkg::TF_STAT_CMD, 8'hff, 8'h50);
    badlen <= 1'b0;
    // abort hides seek-complete and drops ready until next packet command
    pulse(1);
    rd(1'b0, atf_pkg::TF_STAT_CMD, 8'h50, 8'h00);
    rd(1'b0, atf_pkg::TF_FEAT_ERR, 8'h0c, 8'h04);
    pulse(2);
    rd(1'b0, atf_pkg::TF_STAT_CMD, 8'h50, 8'h50);
    // rejected identify/read
    seek_rdy <= 1'b0;
    pulse(3);
    rd(1'b0, atf_pkg::TF_STAT_CMD, 8'hff, atf_pkg::STAT_REJECT);
    rd(1'b0, atf_pkg::TF_FEAT_ERR, 8'hff, atf_pkg::ERR_REJECT);
    // packet soft reset reloads count after a host write
    wr(1'b0, atf_pkg::TF_SECCNT, 8'h55);
    pulse(4);
    rd(1'b0, atf_pkg::TF_STAT_CMD, 8'hff, atf_pkg::STAT_PKT_RST);
    rd(1'b0, atf_pkg::TF_SECCNT, 8'hff, atf_pkg::SECCNT_RST);
    rd(1'b0, atf_pkg::TF_CYLHI, 8'hff, atf_pkg::CYLHI_RST);
    // soft reset bit: full reload, seek hidden even with seek ready
    seek_rdy <= 1'b1;
    wr(1'b0, atf_pkg::TF_SECNUM, 8'h77);
    wr(1'b1, atf_pkg::TF_DEVCTL, 8'h04);
    chk({7'h00, soft_rst}, 8'h01);
    wr(1'b1, atf_pkg::TF_DEVCTL, 8'h00);
    chk_regs;
    // wrong method bit leaves busy stuck; hard reset pin recovers
    wr(1'b0, atf_pkg::TF_FEAT_ERR, 8'h01);
    dev_owns <= 1'b1;
    rd(1'b0, atf_pkg::TF_STAT_CMD, 8'h80, 8'h80);
    hard_req <= 1'b1;
    repeat (2) @(posedge sys_clk);
    hard_req <= 1'b0;
    dev_owns <= 1'b0;
    repeat (6) @(posedge sys_clk);
    chk({7'h00, dma_sel}, 8'h00);
    chk_regs;
    // power-up over: active line no longer pulled for activity
    repeat (HS + 10) @(posedge sys_clk);
    pulse(2);
    chk({7'h00, act_oe}, 8'h00);
    chk({7'h00, act_line}, 8'h01);
    chk({7'h00, diag_line}, 8'h01);
    // as master the unit only listens; it never pulls either line
    is_slave <= 1'b0;
    wr(1'b1, atf_pkg::TF_DEVCTL, 8'h04);
    wr(1'b1, atf_pkg::TF_DEVCTL, 8'h00);
    repeat (4) @(posedge sys_clk);
    chk({6'h00, act_oe, diag_oe}, 8'h00);
    conclude;
  end
endmodule // atf_regs_tb
`default_nettype wire
